// ==== logic/opcode_map_pkg.sv ====
// Purpose: Shared types and constants for the opcode map decoder.
// Assumes: Opcodes are 8 bits; cycle counts fit in 4 bits.
// Notes: Cycle pairs are given for the two process variants.
package opcode_map_pkg;

    typedef enum logic [3:0] {
        mode_none, mode_inherent, mode_immediate, mode_direct, mode_extended,
        relative_mode, mode_bit_test_branch, mode_bit_set_clear, mode_accumulator,
        mode_index_register, mode_indexed, indexed_short_offset_mode, indexed_long_offset_mode
    } addr_mode_t;

    typedef enum logic [6:0] {
        op_illegal, op_brset, op_brclr, op_bset, op_bclr,
        op_bra, op_brn, op_bhi, op_bls, op_bcc, branch_if_carry_set, op_bne, op_beq,
        op_bhcc, op_bhcs, op_bpl, op_bmi, op_bmc, op_bms, op_bil, op_bih,
        op_neg, ones_complement_op, op_lsr, op_ror, op_asr, op_lsl, op_rol, op_dec,
        op_inc, op_tst, op_clr,
        op_rti, op_rts, op_swi, op_stop, op_wait,
        op_tax, op_clc, op_sec, op_cli, op_sei, op_rsp, op_nop, op_txa,
        op_sub, op_cmp, op_sbc, op_cpx, op_and, op_bit, op_lda, op_sta,
        op_eor, op_adc, op_ora, op_add, op_jmp, op_jsr, op_ldx, op_stx, op_bsr
    } operation_t;

    localparam int OPCODE_W = 8;
    localparam int CYC_W = 4;
    localparam int LEN_W = 2;
    localparam int ADDR_W = 16;
    localparam logic [3:0] DIGIT_REGISTER_MEMORY_FIRST = 4'hA;
    localparam logic [3:0] COL_BTB = 4'h0;
    localparam logic [3:0] COL_BSC = 4'h1;
    localparam logic [3:0] COL_BRANCH = 4'h2;
    localparam logic [3:0] COL_CTRL_A = 4'h8;
    localparam logic [3:0] COL_CTRL_B = 4'h9;
    localparam logic [3:0] ROW_STA = 4'h7;
    localparam logic [3:0] ROW_JMP = 4'hC;
    localparam logic [3:0] ROW_JSR = 4'hD;
    localparam logic [3:0] ROW_STX = 4'hF;
    localparam logic [3:0] ROW_TST = 4'hD;
    localparam logic [CYC_W-1:0] CYC_RTI_HMOS = 4'h9;
    localparam logic [CYC_W-1:0] CYC_RTI_CMOS = 4'h9;
    localparam logic [CYC_W-1:0] CYC_RTS_HMOS = 4'h6;
    localparam logic [CYC_W-1:0] CYC_RTS_CMOS = 4'h6;
    localparam logic [CYC_W-1:0] CYC_SWI_HMOS = 4'hB;
    localparam logic [CYC_W-1:0] CYC_SWI_CMOS = 4'hA;
    localparam logic [CYC_W-1:0] CYC_STOPWAIT_CMOS = 4'h2;

endpackage

// ==== logic/decode_if.sv ====
// Purpose: Carries one opcode to the table lookup and its decoded fields back.
// Assumes: The lookup is purely combinational.
// Notes: A zero HMOS count on a legal opcode marks an opcode that exists only on the CMOS variant.
`timescale 1ns/10ps
`default_nettype none
interface decode_if;
    import opcode_map_pkg::*;
    logic [OPCODE_W-1:0] opcode;
    operation_t op;
    addr_mode_t mode;
    logic [LEN_W-1:0] length;
    logic [CYC_W-1:0] cyc_hmos;
    logic [CYC_W-1:0] cyc_cmos;
    logic illegal;
    modport requester (output opcode, input op, mode, length, cyc_hmos, cyc_cmos, illegal);
    modport table_side (input opcode, output op, mode, length, cyc_hmos, cyc_cmos, illegal);
endinterface
`default_nettype wire

// ==== logic/opcode_map_table.sv ====
// Purpose: Combinational opcode map lookup.
// Assumes: Driven through the table side of the decode interface.
// Notes: Unlisted map squares decode as illegal with zero counts.
`timescale 1ns/10ps
`default_nettype none
module opcode_map_table
    import opcode_map_pkg::*;
(
    decode_if.table_side dec
);

    // One entry worth of result, packed so each map region returns it at once.
    typedef struct packed {
        operation_t op;
        addr_mode_t mode;
        logic [LEN_W-1:0] length;
        logic [CYC_W-1:0] hm;
        logic [CYC_W-1:0] cm;
    } entry_t;

    function automatic entry_t mk(input operation_t op, input addr_mode_t mode,
                                  input logic [LEN_W-1:0] len, input logic [CYC_W-1:0] hm,
                                  input logic [CYC_W-1:0] cm);
        entry_t e;
        e.op = op;
        e.mode = mode;
        e.length = len;
        e.hm = hm;
        e.cm = cm;
        return e;
    endfunction

    function automatic entry_t read_modify_write(input logic [3:0] hi, input logic [3:0] lo);
        operation_t op;
        entry_t e;
        op = op_illegal;
        e = mk(op_illegal, mode_none, 2'h0, 4'h0, 4'h0);
        unique case (lo)
            4'h0: op = op_neg;
            4'h3: op = ones_complement_op;
            4'h4: op = op_lsr;
            4'h6: op = op_ror;
            4'h7: op = op_asr;
            4'h8: op = op_lsl;
            4'h9: op = op_rol;
            4'hA: op = op_dec;
            4'hC: op = op_inc;
            4'hD: op = op_tst;
            4'hF: op = op_clr;
            default: op = op_illegal;
        endcase
        if (op != op_illegal) begin
            // Five columns, five addressing modes for each of these operations.
            unique case (hi)
                4'h3: e = mk(op, mode_direct, 2'h2, 4'h6, 4'h5);
                4'h4: e = mk(op, mode_accumulator, 2'h1, 4'h4, 4'h3);
                4'h5: e = mk(op, mode_index_register, 2'h1, 4'h4, 4'h3);
                4'h6: e = mk(op, indexed_short_offset_mode, 2'h2, 4'h7, 4'h6);
                default: e = mk(op, mode_indexed, 2'h1, 4'h6, 4'h5);
            endcase
            // Test only reads its operand, so the CMOS part saves a cycle in memory forms.
            if (lo == ROW_TST && (hi == 4'h3 || hi == 4'h6 || hi == 4'h7)) begin
                e.cm = 4'(e.cm - 4'h1);
            end
        end
        return e;
    endfunction

    function automatic entry_t register_memory(input logic [3:0] hi, input logic [3:0] lo);
        operation_t op;
        entry_t e;
        logic [CYC_W-1:0] extra;
        op = operation_t'(7'(int'(op_sub) + int'(lo)));
        extra = 4'h0;
        unique case (hi)
            4'hA: e = mk(op, mode_immediate, 2'h2, 4'h2, 4'h2);
            4'hB: e = mk(op, mode_direct, 2'h2, 4'h4, 4'h3);
            4'hC: e = mk(op, mode_extended, 2'h3, 4'h5, 4'h4);
            4'hD: e = mk(op, indexed_long_offset_mode, 2'h3, 4'h6, 4'h5);
            4'hE: e = mk(op, indexed_short_offset_mode, 2'h2, 4'h5, 4'h4);
            default: e = mk(op, mode_indexed, 2'h1, 4'h4, 4'h3);
        endcase
        if (lo == ROW_STA || lo == ROW_STX) begin
            extra = 4'h1;
        end
        if (lo == ROW_JSR) begin
            extra = 4'h3;
        end
        e.hm = 4'(e.hm + extra);
        e.cm = (lo == ROW_JSR) ? 4'(e.cm + 4'h2) : 4'(e.cm + extra);
        if (lo == ROW_JMP) begin
            e.hm = 4'(e.hm - 4'h1);
            e.cm = 4'(e.cm - 4'h1);
        end
        if (hi == 4'hA) begin
            if (lo == ROW_STA || lo == ROW_STX || lo == ROW_JMP) begin
                e = mk(op_illegal, mode_none, 2'h0, 4'h0, 4'h0);
            end else if (lo == ROW_JSR) begin
                e = mk(op_bsr, relative_mode, 2'h2, 4'h8, 4'h6);
            end
        end
        return e;
    endfunction

    function automatic entry_t control(input logic [3:0] hi, input logic [3:0] lo);
        entry_t e;
        e = mk(op_illegal, mode_none, 2'h0, 4'h0, 4'h0);
        if (hi == COL_CTRL_A) begin
            unique case (lo)
                4'h0: e = mk(op_rti, mode_inherent, 2'h1, CYC_RTI_HMOS, CYC_RTI_CMOS);
                4'h1: e = mk(op_rts, mode_inherent, 2'h1, CYC_RTS_HMOS, CYC_RTS_CMOS);
                4'h3: e = mk(op_swi, mode_inherent, 2'h1, CYC_SWI_HMOS, CYC_SWI_CMOS);
                // Low power instructions exist only on the CMOS variant.
                4'hE: e = mk(op_stop, mode_inherent, 2'h1, 4'h0, CYC_STOPWAIT_CMOS);
                4'hF: e = mk(op_wait, mode_inherent, 2'h1, 4'h0, CYC_STOPWAIT_CMOS);
                default: e = mk(op_illegal, mode_none, 2'h0, 4'h0, 4'h0);
            endcase
        end else begin
            unique case (lo)
                4'h7: e = mk(op_tax, mode_inherent, 2'h1, 4'h2, 4'h2);
                4'h8: e = mk(op_clc, mode_inherent, 2'h1, 4'h2, 4'h2);
                4'h9: e = mk(op_sec, mode_inherent, 2'h1, 4'h2, 4'h2);
                4'hA: e = mk(op_cli, mode_inherent, 2'h1, 4'h2, 4'h2);
                4'hB: e = mk(op_sei, mode_inherent, 2'h1, 4'h2, 4'h2);
                4'hC: e = mk(op_rsp, mode_inherent, 2'h1, 4'h2, 4'h2);
                4'hD: e = mk(op_nop, mode_inherent, 2'h1, 4'h2, 4'h2);
                4'hF: e = mk(op_txa, mode_inherent, 2'h1, 4'h2, 4'h2);
                default: e = mk(op_illegal, mode_none, 2'h0, 4'h0, 4'h0);
            endcase
        end
        return e;
    endfunction

    logic [3:0] upper_hex_digit;
    logic [3:0] lower_hex_digit;
    entry_t ent;

    assign upper_hex_digit = dec.opcode[7:4];
    assign lower_hex_digit = dec.opcode[3:0];

    always_comb begin
        ent = mk(op_illegal, mode_none, 2'h0, 4'h0, 4'h0);
        if (upper_hex_digit == COL_BTB) begin
            ent = mk(lower_hex_digit[0] ? op_brclr : op_brset, mode_bit_test_branch, 2'h3, 4'hA,
                     (lower_hex_digit >= 4'hE) ? 4'h7 : 4'h5);
        end else if (upper_hex_digit == COL_BSC) begin
            ent = mk(lower_hex_digit[0] ? op_bclr : op_bset, mode_bit_set_clear, 2'h2, 4'h7, 4'h5);
        end else if (upper_hex_digit == COL_BRANCH) begin
            // Row order of the branch column matches the enum order.
            ent = mk(operation_t'(7'(int'(op_bra) + int'(lower_hex_digit))), relative_mode,
                     2'h2, 4'h4, 4'h3);
        end else if (upper_hex_digit == COL_CTRL_A || upper_hex_digit == COL_CTRL_B) begin
            ent = control(upper_hex_digit, lower_hex_digit);
        end else if (upper_hex_digit >= DIGIT_REGISTER_MEMORY_FIRST) begin
            ent = register_memory(upper_hex_digit, lower_hex_digit);
        end else begin
            ent = read_modify_write(upper_hex_digit, lower_hex_digit);
        end
    end

    assign dec.op = ent.op;
    assign dec.mode = ent.mode;
    assign dec.length = ent.length;
    assign dec.cyc_hmos = ent.hm;
    assign dec.cyc_cmos = ent.cm;
    assign dec.illegal = (ent.op == op_illegal);

endmodule
`default_nettype wire

// ==== logic/opcode_map_decoder.sv ====
// Contract
// - Upper opcode digit picks the map column, lower digit picks the row.
// - Opcode 25 decodes as branch if carry set, relative addressing.
// - Ones complement has five opcodes, each in a different addressing mode.
// - Opcode F0 decodes as subtract with indexed, no offset addressing.
// - Every defined opcode yields length and a cycle count per process variant.
// - Short offset indexed adds one 8-bit offset byte to the index register.
// - Long offset indexed adds a 16-bit offset from two following bytes.
//
// Purpose: Registered opcode decoder with operand address forming for indexed modes.
// Assumes: Fetch logic on the same clock presents opcode and offset bytes with a valid strobe.
// Notes: Results appear one cycle after the strobe and hold until the next strobe.
`timescale 1ns/10ps
`default_nettype none
module opcode_map_decoder
    import opcode_map_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_valid,
    input wire logic [OPCODE_W-1:0] i_opcode,
    input wire logic [7:0] i_index,
    input wire logic [7:0] i_offset_hi,
    input wire logic [7:0] i_offset_lo,
    output logic o_valid,
    output operation_t o_op,
    output addr_mode_t o_mode,
    output logic [LEN_W-1:0] o_length,
    output logic [CYC_W-1:0] o_cyc_hmos,
    output logic [CYC_W-1:0] o_cyc_cmos,
    output logic o_illegal,
    output logic o_cmos_only,
    output logic [ADDR_W-1:0] o_operand_addr
);

    decode_if dec ();

    opcode_map_table u_table (
        .dec(dec)
    );

    logic valid_q, valid_d;
    operation_t op_q, op_d;
    addr_mode_t mode_q, mode_d;
    logic [LEN_W-1:0] length_q, length_d;
    logic [CYC_W-1:0] hm_q, hm_d, cm_q, cm_d;
    logic illegal_q, illegal_d;
    logic cmos_only_q, cmos_only_d;
    logic [ADDR_W-1:0] addr_q, addr_d;

    assign dec.opcode = i_opcode;

    always_comb begin
        valid_d = i_valid;
        op_d = op_q;
        mode_d = mode_q;
        length_d = length_q;
        hm_d = hm_q;
        cm_d = cm_q;
        illegal_d = illegal_q;
        cmos_only_d = cmos_only_q;
        addr_d = addr_q;
        if (i_valid) begin
            op_d = dec.op;
            mode_d = dec.mode;
            length_d = dec.length;
            hm_d = dec.cyc_hmos;
            cm_d = dec.cyc_cmos;
            // Illegal codes carry zero counts so sequencing cannot run them by accident.
            illegal_d = dec.illegal;
            cmos_only_d = !dec.illegal && dec.cyc_hmos == 4'h0;
            unique case (dec.mode)
                indexed_short_offset_mode: addr_d = ADDR_W'({8'h00, i_index} + {8'h00, i_offset_lo});
                indexed_long_offset_mode: addr_d = ADDR_W'({8'h00, i_index} + {i_offset_hi, i_offset_lo});
                mode_indexed: addr_d = {8'h00, i_index};
                default: addr_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            valid_q <= 1'b0;
            op_q <= op_illegal;
            mode_q <= mode_none;
            length_q <= 2'h0;
            hm_q <= 4'h0;
            cm_q <= 4'h0;
            illegal_q <= 1'b0;
            cmos_only_q <= 1'b0;
            addr_q <= 16'h0000;
        end else begin
            valid_q <= valid_d;
            op_q <= op_d;
            mode_q <= mode_d;
            length_q <= length_d;
            hm_q <= hm_d;
            cm_q <= cm_d;
            illegal_q <= illegal_d;
            cmos_only_q <= cmos_only_d;
            addr_q <= addr_d;
        end
    end

    assign o_valid = valid_q;
    assign o_op = op_q;
    assign o_mode = mode_q;
    assign o_length = length_q;
    assign o_cyc_hmos = hm_q;
    assign o_cyc_cmos = cm_q;
    assign o_illegal = illegal_q;
    assign o_cmos_only = cmos_only_q;
    assign o_operand_addr = addr_q;

endmodule
`default_nettype wire

// ==== tb/opcode_map_decoder_chk.sv ====
// Purpose: Concurrent checks on the decoder top ports.
// Assumes: One clock domain with a synchronous active high reset.
// Notes: Address checks look back one cycle to the strobe that caused them.
`timescale 1ns/10ps
`default_nettype none
module opcode_map_decoder_chk
    import opcode_map_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_valid,
    input wire logic [OPCODE_W-1:0] i_opcode,
    input wire logic [7:0] i_index,
    input wire logic [7:0] i_offset_hi,
    input wire logic [7:0] i_offset_lo,
    input wire logic o_valid,
    input wire operation_t o_op,
    input wire addr_mode_t o_mode,
    input wire logic [LEN_W-1:0] o_length,
    input wire logic [CYC_W-1:0] o_cyc_hmos,
    input wire logic [CYC_W-1:0] o_cyc_cmos,
    input wire logic o_illegal,
    input wire logic o_cmos_only,
    input wire logic [ADDR_W-1:0] o_operand_addr
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    sequence s_strobe(logic [7:0] code);
        i_valid && i_opcode == code;
    endsequence
    sequence s_answer;
        o_valid && !o_illegal;
    endsequence
    answer_latency_a: assert property (i_valid |=> o_valid) else $error("answer missing after strobe");
    no_spurious_a: assert property (!i_valid |=> !o_valid) else $error("answer without strobe");
    fields_hold_a: assert property (!i_valid |=>
        $stable(o_op) && $stable(o_mode) && $stable(o_length) && $stable(o_operand_addr)) else $error("fields moved");
    relative_map_a: assert property (s_strobe(8'h25) |=>
        o_op == branch_if_carry_set && o_mode == relative_mode) else $error("opcode 25 misdecoded");
    branch_column_a: assert property (i_valid && i_opcode[7:4] == 4'h2 |=>
        o_mode == relative_mode && o_length == 2'h2) else $error("column 2 not relative");
    sub_indexed_a: assert property (s_strobe(8'hF0) |=>
        o_op == op_sub && o_mode == mode_indexed && o_length == 2'h1) else $error("opcode F0 misdecoded");
    complement_row_a: assert property (i_valid && i_opcode[3:0] == 4'h3 &&
        i_opcode[7:4] inside {[4'h3:4'h7]} |=> o_op == ones_complement_op) else $error("complement row misdecoded");
    short_offset_a: assert property (s_answer ##0 o_mode == indexed_short_offset_mode |->
        o_operand_addr == {8'h00, $past(i_index)} + {8'h00, $past(i_offset_lo)}) else $error("short offset address");
    long_offset_a: assert property (s_answer ##0 o_mode == indexed_long_offset_mode |->
        o_operand_addr == {8'h00, $past(i_index)} + {$past(i_offset_hi), $past(i_offset_lo)})
        else $error("long offset address");
    defined_counts_a: assert property (s_answer |-> o_length != 2'h0 && o_cyc_cmos != 4'h0)
        else $error("zero count");
    illegal_zero_a: assert property (o_valid && o_illegal |-> o_op == op_illegal && o_length == 2'h0)
        else $error("illegal answer not cleared");
endmodule
bind opcode_map_decoder opcode_map_decoder_chk chk_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_valid(i_valid),
    .i_opcode(i_opcode), .i_index(i_index), .i_offset_hi(i_offset_hi), .i_offset_lo(i_offset_lo), .o_valid(o_valid),
    .o_op(o_op), .o_mode(o_mode), .o_length(o_length), .o_cyc_hmos(o_cyc_hmos), .o_cyc_cmos(o_cyc_cmos),
    .o_illegal(o_illegal), .o_cmos_only(o_cmos_only), .o_operand_addr(o_operand_addr));
`default_nettype wire

// ==== tb/fetch_model.sv ====
// Purpose: Fetch side model that presents opcode and operand bytes with a strobe.
// Assumes: Its task is called at a falling edge of the clock.
// Notes: Released byte lines show the inverse of their last value.
`timescale 1ns/10ps
`default_nettype none
module fetch_model (
    input wire logic i_ref_clk,
    output logic o_valid,
    output logic [7:0] o_opcode,
    output logic [7:0] o_index,
    output logic [7:0] o_offset_hi,
    output logic [7:0] o_offset_lo
);
    initial begin
        o_valid = 1'b0;
        o_opcode = 8'h00;
        o_index = 8'h00;
        o_offset_hi = 8'h00;
        o_offset_lo = 8'h00;
    end
    // Holding the strobe lets the caller send the next opcode back to back.
    task automatic issue(input logic [7:0] op, input logic [7:0] idx, input logic [7:0] hi, input logic [7:0] lo,
        input bit hold);
        o_valid = 1'b1;
        o_opcode = op;
        o_index = idx;
        o_offset_hi = hi;
        o_offset_lo = lo;
        @(negedge i_ref_clk);
        if (!hold) begin
            // Inverted stale bytes keep a late sample from looking correct by chance.
            o_valid = 1'b0;
            o_opcode = ~o_opcode;
            o_index = ~o_index;
            o_offset_hi = ~o_offset_hi;
            o_offset_lo = ~o_offset_lo;
        end
    endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the opcode map decoder.
// Assumes: Answers arrive one cycle after each strobe.
// Notes: Results are sampled at the falling edge after the strobe edge.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import opcode_map_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_valid, o_valid, o_illegal, o_cmos_only;
    logic [7:0] i_opcode, i_index, i_offset_hi, i_offset_lo;
    operation_t o_op;
    addr_mode_t o_mode;
    logic [1:0] o_length;
    logic [3:0] o_cyc_hmos, o_cyc_cmos;
    logic [15:0] o_operand_addr;
    int num_errors = 0;
    int compares = 0;
    always #5 i_ref_clk = ~i_ref_clk;
    fetch_model fm (.i_ref_clk(i_ref_clk), .o_valid(i_valid), .o_opcode(i_opcode), .o_index(i_index),
        .o_offset_hi(i_offset_hi), .o_offset_lo(i_offset_lo));
    opcode_map_decoder uut (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_valid(i_valid), .i_opcode(i_opcode),
        .i_index(i_index), .i_offset_hi(i_offset_hi), .i_offset_lo(i_offset_lo), .o_valid(o_valid), .o_op(o_op),
        .o_mode(o_mode), .o_length(o_length), .o_cyc_hmos(o_cyc_hmos), .o_cyc_cmos(o_cyc_cmos),
        .o_illegal(o_illegal), .o_cmos_only(o_cmos_only), .o_operand_addr(o_operand_addr));
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // A zero HMOS count on a defined operation marks a CMOS only opcode.
    task automatic dec(input logic [7:0] op, input logic [7:0] idx, input logic [7:0] hi, input logic [7:0] lo,
        input bit hold, input operation_t e_op, input addr_mode_t e_md, input logic [1:0] e_len,
        input logic [3:0] e_h, input logic [3:0] e_c, input logic [15:0] e_adr);
        fm.issue(op, idx, hi, lo, hold);
        chk("valid", 16'h0001, o_valid);
        chk("op", e_op, o_op);
        chk("mode", e_md, o_mode);
        chk("length", e_len, o_length);
        chk("hmos cycles", e_h, o_cyc_hmos);
        chk("cmos cycles", e_c, o_cyc_cmos);
        chk("address", e_adr, o_operand_addr);
        chk("illegal", e_op == op_illegal, o_illegal);
        chk("cmos only", e_h == 4'h0 && e_op != op_illegal, o_cmos_only);
    endtask
    task automatic t_reset();
        chk("valid", 16'h0000, o_valid);
        chk("op", op_illegal, o_op);
        chk("illegal", 16'h0000, o_illegal);
        $display("test reset done");
    endtask
    task automatic t_columns();
        dec(8'h25, 8'h00, 8'h00, 8'h00, 0, branch_if_carry_set, relative_mode, 2'h2, 4'h4, 4'h3,
            16'h0000);
        @(negedge i_ref_clk);
        chk("valid", 16'h0000, o_valid);
        chk("op", branch_if_carry_set, o_op);
        dec(8'h24, 8'h00, 8'h00, 8'h00, 1, op_bcc, relative_mode, 2'h2, 4'h4, 4'h3, 16'h0000);
        dec(8'h15, 8'h00, 8'h00, 8'h00, 1, op_bclr, mode_bit_set_clear, 2'h2, 4'h7, 4'h5, 16'h0000);
        dec(8'h0E, 8'h00, 8'h00, 8'h00, 0, op_brset, mode_bit_test_branch, 2'h3, 4'hA, 4'h7, 16'h0000);
        $display("test columns done");
    endtask
    task automatic t_complement();
        logic [7:0] ops [5] = '{8'h33, 8'h43, 8'h53, 8'h63, 8'h73};
        addr_mode_t md [5] = '{mode_direct, mode_accumulator, mode_index_register, indexed_short_offset_mode,
            mode_indexed};
        logic [1:0] len [5] = '{2'h2, 2'h1, 2'h1, 2'h2, 2'h1};
        logic [3:0] hm [5] = '{4'h6, 4'h4, 4'h4, 4'h7, 4'h6};
        logic [15:0] adr [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0110, 16'h00F0};
        for (int i = 0; i < 5; i++) begin
            dec(ops[i], 8'hF0, 8'h00, 8'h20, i < 4, ones_complement_op, md[i], len[i], hm[i], hm[i] - 4'h1,
                adr[i]);
        end
        $display("test complement done");
    endtask
    task automatic t_indexed();
        dec(8'hF0, 8'h10, 8'h00, 8'h00, 1, op_sub, mode_indexed, 2'h1, 4'h4, 4'h3, 16'h0010);
        dec(8'hE0, 8'hFF, 8'h00, 8'hFF, 1, op_sub, indexed_short_offset_mode, 2'h2, 4'h5, 4'h4, 16'h01FE);
        dec(8'hEF, 8'h10, 8'h00, 8'h05, 1, op_stx, indexed_short_offset_mode, 2'h2, 4'h6, 4'h5, 16'h0015);
        dec(8'hAE, 8'h00, 8'h00, 8'h00, 1, op_ldx, mode_immediate, 2'h2, 4'h2, 4'h2, 16'h0000);
        dec(8'hAD, 8'h00, 8'h00, 8'h00, 1, op_bsr, relative_mode, 2'h2, 4'h8, 4'h6, 16'h0000);
        dec(8'hD0, 8'h01, 8'h12, 8'h34, 1, op_sub, indexed_long_offset_mode, 2'h3, 4'h6, 4'h5, 16'h1235);
        dec(8'hD0, 8'hFF, 8'hFF, 8'hFF, 0, op_sub, indexed_long_offset_mode, 2'h3, 4'h6, 4'h5, 16'h00FE);
        $display("test indexed done");
    endtask
    task automatic t_illegal();
        logic [7:0] bad [4] = '{8'h31, 8'h82, 8'h9E, 8'hA7};
        foreach (bad[i]) begin
            dec(bad[i], 8'h55, 8'h55, 8'h55, 1, op_illegal, mode_none, 2'h0, 4'h0, 4'h0, 16'h0000);
        end
        dec(8'h8E, 8'h00, 8'h00, 8'h00, 1, op_stop, mode_inherent, 2'h1, 4'h0, 4'h2, 16'h0000);
        dec(8'h8F, 8'h00, 8'h00, 8'h00, 0, op_wait, mode_inherent, 2'h1, 4'h0, 4'h2, 16'h0000);
        $display("test illegal done");
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge i_ref_clk);
        i_srst = 1'b0;
        t_reset();
        t_columns();
        // A released strobe must stand for an edge before the next test raises it again.
        @(negedge i_ref_clk);
        t_complement();
        @(negedge i_ref_clk);
        t_indexed();
        @(negedge i_ref_clk);
        t_illegal();
        print_verdict();
    end
endmodule
`default_nettype wire
